// file: docc_clock_ctrl.sv
// Dual oscillator clock controller top with its control register
`default_nettype none

module docc_clock_ctrl #(
  parameter int STARTUP_SLOW = docc_pkg::STARTUP_SLOW_PERIODS,
  parameter int STARTUP_FAST = docc_pkg::STARTUP_FAST_PERIODS
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output var  logic [7:0] reg_rd_data,
  input  wire logic       sleep_state,
  input  wire logic       idle_state,
  input  wire logic       brownout_reset,
  output var  logic       fast_clock,
  output var  logic       slow_clock,
  output var  logic       cpu_core_clock,
  output var  logic       instruction_clock,
  output var  logic       adc_sample_clock,
  output var  logic       fast_osc_running,
  output var  logic       slow_osc_running,
  output var  logic       cpu_released
);

  // Start-up counter wide enough for the longer of the two waits
  localparam int BOOT_W = $clog2(STARTUP_SLOW > STARTUP_FAST ?
                                 STARTUP_SLOW : STARTUP_FAST) + 1;
  localparam logic [BOOT_W-1:0] BOOT_SLOW_LAST =
    BOOT_W'(STARTUP_SLOW - 1);
  localparam logic [BOOT_W-1:0] BOOT_FAST_LAST =
    BOOT_W'(STARTUP_FAST - 1);

  // Register, divider, switch and start-up state
  logic [4:0]              csc_reg;
  logic                    bor_sync;
  logic                    fast_tick;
  logic                    slow_tick;
  logic                    adc_tick;
  logic                    instr_tick;
  logic [11:0]             fast_period;
  logic [11:0]             adc_ratio;
  logic                    fast_run_reg;
  logic                    slow_run_reg;
  logic                    sel_active_reg;
  logic                    hold_reg;
  logic                    cpu_tick_reg;
  logic                    released_reg;
  logic [BOOT_W-1:0]       boot_cnt_reg;
  docc_pkg::docc_boot_t    boot_state_reg;
  logic                    csc_hit;
  logic                    enables_locked;
  logic                    old_tick;
  logic                    old_running;
  logic                    instr_run;

  ////////////////////////////////////////////////////////////////////////
  // Brown-out detector level comes from the analog side
  docc_sync2 u_bor_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (brownout_reset),
    .sync_out (bor_sync)
  );

  // Single register, so a full address match selects it
  assign csc_hit        = reg_addr == docc_pkg::CSC_ADDR;
  assign enables_locked = sleep_state | bor_sync;

  ////////////////////////////////////////////////////////////////////////
  // Control register; brown-out holds it at its reset value
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      csc_reg <= docc_pkg::CSC_RESET;
    end else if (bor_sync) begin
      csc_reg <= docc_pkg::CSC_RESET;
    end else if (reg_wr_en && csc_hit) begin
      csc_reg[docc_pkg::CSC_FREQ_HI:docc_pkg::CSC_CPU_SEL] <=
        reg_wr_data[docc_pkg::CSC_FREQ_HI:docc_pkg::CSC_CPU_SEL];
      // Enable bits frozen while asleep or browned out
      if (!enables_locked) begin
        csc_reg[docc_pkg::CSC_FAST_EN] <=
          reg_wr_data[docc_pkg::CSC_FAST_EN];
        csc_reg[docc_pkg::CSC_SLOW_EN] <=
          reg_wr_data[docc_pkg::CSC_SLOW_EN];
      end
    end
  end

  // Registered read; other addresses answer zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en && csc_hit) begin
      reg_rd_data <= {3'h0, csc_reg};
    end else begin
      reg_rd_data <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fast run state; stopping on brown-out gives a full restart period
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fast_run_reg <= 1'b0;
    end else begin
      fast_run_reg <= csc_reg[docc_pkg::CSC_FAST_EN] & ~sleep_state &
                      ~bor_sync;
    end
  end

  // Slow run state: stopped in sleep, back on its own at wake
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      slow_run_reg <= 1'b0;
    end else begin
      slow_run_reg <= csc_reg[docc_pkg::CSC_SLOW_EN] & ~sleep_state &
                      ~bor_sync;
    end
  end

  // Fast period per frequency code; both top codes give 8MHz
  always_comb begin
    case (csc_reg[docc_pkg::CSC_FREQ_HI:docc_pkg::CSC_FREQ_LO])
      docc_pkg::FREQ_2M: begin
        fast_period = docc_pkg::FAST_2M_CYC;
        adc_ratio   = docc_pkg::ADC_DIV_2M;
      end
      docc_pkg::FREQ_4M: begin
        fast_period = docc_pkg::FAST_4M_CYC;
        adc_ratio   = docc_pkg::ADC_DIV_4M;
      end
      default: begin
        fast_period = docc_pkg::FAST_8M_CYC;
        adc_ratio   = docc_pkg::ADC_DIV_8M;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator models as enable pulses at the oscillator rate
  docc_tick_div #(.W(docc_pkg::DIV_W)) u_fast_osc (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .run     (fast_run_reg),
    .step    (1'b1),
    .modulus (fast_period),
    .tick    (fast_tick)
  );

  // Slow one runs from reset with no software help
  docc_tick_div #(.W(docc_pkg::DIV_W)) u_slow_osc (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .run     (slow_run_reg),
    .step    (1'b1),
    .modulus (docc_pkg::SLOW_CYC),
    .tick    (slow_tick)
  );

  // Converter clock counts fast periods, so it stays at 1MHz
  docc_tick_div #(.W(docc_pkg::DIV_W)) u_adc_div (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .run     (fast_run_reg),
    .step    (fast_tick),
    .modulus (adc_ratio),
    .tick    (adc_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Start-up wait after reset or brown-out
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      boot_state_reg <= docc_pkg::DOCC_WAIT_SLOW;
      boot_cnt_reg   <= '0;
      released_reg   <= 1'b0;
    end else if (bor_sync) begin
      // Brown-out restarts the wait from the slow count
      boot_state_reg <= docc_pkg::DOCC_WAIT_SLOW;
      boot_cnt_reg   <= '0;
      released_reg   <= 1'b0;
    end else begin
      // Periods are counted on whole oscillator ticks
      case (boot_state_reg)
        docc_pkg::DOCC_WAIT_SLOW: begin
          if (slow_tick) begin
            if (boot_cnt_reg == BOOT_SLOW_LAST) begin
              boot_state_reg <= docc_pkg::DOCC_WAIT_FAST;
              boot_cnt_reg   <= '0;
            end else begin
              boot_cnt_reg <= boot_cnt_reg + BOOT_W'(1);
            end
          end
        end
        docc_pkg::DOCC_WAIT_FAST: begin
          if (fast_tick) begin
            if (boot_cnt_reg == BOOT_FAST_LAST) begin
              boot_state_reg <= docc_pkg::DOCC_RUN;
              boot_cnt_reg   <= '0;
              released_reg   <= 1'b1;
            end else begin
              boot_cnt_reg <= boot_cnt_reg + BOOT_W'(1);
            end
          end
        end
        docc_pkg::DOCC_RUN: begin
          released_reg <= 1'b1;
        end
        default: begin
          boot_state_reg <= docc_pkg::DOCC_WAIT_SLOW;
          boot_cnt_reg   <= '0;
          released_reg   <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source switch waits for the old period to end, then drops the
  // first new pulse: a free-running source may be mid-period
  assign old_tick    = sel_active_reg ? slow_tick : fast_tick;
  assign old_running = sel_active_reg ? slow_run_reg : fast_run_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sel_active_reg <= 1'b0;
      hold_reg       <= 1'b0;
    end else if (sel_active_reg != csc_reg[docc_pkg::CSC_CPU_SEL]) begin
      if (old_tick || !old_running) begin
        sel_active_reg <= csc_reg[docc_pkg::CSC_CPU_SEL];
        hold_reg       <= 1'b1;
      end
    end else if (hold_reg && (old_tick || !old_running)) begin
      hold_reg <= 1'b0;
    end
  end

  // CPU clock pulse from the active source
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_tick_reg <= 1'b0;
    end else begin
      cpu_tick_reg <= released_reg & ~hold_reg & old_tick &
                      (sel_active_reg == csc_reg[docc_pkg::CSC_CPU_SEL]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction clock: every fourth CPU pulse, halted in idle
  assign instr_run = released_reg & ~idle_state & ~sleep_state;

  docc_tick_div #(.W(docc_pkg::DIV_W)) u_instr_div (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .run     (instr_run),
    .step    (cpu_tick_reg),
    .modulus (docc_pkg::INSTR_DIV),
    .tick    (instr_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock pulse outputs, one cycle late so every output is a flop
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fast_clock        <= 1'b0;
      slow_clock        <= 1'b0;
      cpu_core_clock    <= 1'b0;
      instruction_clock <= 1'b0;
      adc_sample_clock  <= 1'b0;
    end else begin
      fast_clock        <= fast_tick;
      slow_clock        <= slow_tick;
      cpu_core_clock    <= cpu_tick_reg;
      instruction_clock <= instr_tick;
      adc_sample_clock  <= adc_tick;
    end
  end

  // Oscillator status outputs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fast_osc_running  <= 1'b0;
      slow_osc_running  <= 1'b0;
    end else begin
      fast_osc_running  <= fast_run_reg;
      slow_osc_running  <= slow_run_reg;
    end
  end

  // Start-up status output
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_released      <= 1'b0;
    end else begin
      cpu_released      <= released_reg;
    end
  end

endmodule : docc_clock_ctrl

`default_nettype wire

// file: docc_pkg.sv
// Constants shared by the dual oscillator clock controller files
// What this block does
// - Frequency code 11/10=8MHz, 01=4MHz, 00=2MHz
// - Bit 2 set picks slow source
// - Bit 1 enables the fast oscillator
// - Bit 0 enables the slow oscillator
// - Enable bits ignored in sleep or brown-out
// - Instruction clock is CPU clock over four
// - Slow and fast oscillators both start at power up
// - Slow oscillator stops in sleep, restarts on wake
// - Sleep stops both; idle keeps both, halts execution
// - Converter gets fixed 1MHz from fast clock
// - Full reset loads 0x03 into the register
// - Brown-out waits 2048 slow, 1024 fast periods
`default_nettype none

package docc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Rates
  localparam int CLK_HZ     = 100_000_000;
  localparam int FAST_8M_HZ = 8_000_000;
  localparam int FAST_4M_HZ = 4_000_000;
  localparam int FAST_2M_HZ = 2_000_000;
  localparam int SLOW_HZ    = 32_000;
  localparam int ADC_HZ     = 1_000_000;

  // Oscillator periods in system cycles, rounded down
  localparam int          DIV_W        = 12;
  localparam logic [11:0] FAST_8M_CYC  = 12'(CLK_HZ / FAST_8M_HZ);
  localparam logic [11:0] FAST_4M_CYC  = 12'(CLK_HZ / FAST_4M_HZ);
  localparam logic [11:0] FAST_2M_CYC  = 12'(CLK_HZ / FAST_2M_HZ);
  localparam logic [11:0] SLOW_CYC     = 12'(CLK_HZ / SLOW_HZ);

  // Fast periods per converter period, per frequency code
  localparam logic [11:0] ADC_DIV_8M   = 12'(FAST_8M_HZ / ADC_HZ);
  localparam logic [11:0] ADC_DIV_4M   = 12'(FAST_4M_HZ / ADC_HZ);
  localparam logic [11:0] ADC_DIV_2M   = 12'(FAST_2M_HZ / ADC_HZ);

  // CPU periods per instruction period
  localparam logic [11:0] INSTR_DIV    = 12'h004;

  // Start-up wait after brown-out, in oscillator periods
  localparam int STARTUP_SLOW_PERIODS = 2048;
  localparam int STARTUP_FAST_PERIODS = 1024;

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] CSC_ADDR      = 8'h38;
  localparam logic [4:0] CSC_RESET     = 5'h03;
  localparam int         CSC_SLOW_EN   = 0;
  localparam int         CSC_FAST_EN   = 1;
  localparam int         CSC_CPU_SEL   = 2;
  localparam int         CSC_FREQ_LO   = 3;
  localparam int         CSC_FREQ_HI   = 4;

  localparam logic [1:0] FREQ_2M       = 2'h0;
  localparam logic [1:0] FREQ_4M       = 2'h1;

  typedef enum logic [1:0] {
    DOCC_WAIT_SLOW,
    DOCC_WAIT_FAST,
    DOCC_RUN
  } docc_boot_t;

endpackage : docc_pkg

`default_nettype wire

// file: docc_sync2.sv
// Two-stage synchroniser for one asynchronous level
`default_nettype none

module docc_sync2 (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_reg;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : docc_sync2

`default_nettype wire

// file: docc_tick_div.sv
// Enable-pulse divider: one pulse every modulus steps while running
`default_nettype none

module docc_tick_div #(
  parameter int W = 12
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         run,
  input  wire logic         step,
  input  wire logic [W-1:0] modulus,
  output var  logic         tick
);

  logic [W-1:0] count_reg;

  ////////////////////////////////////////////////////////////////////////
  // Stopping clears the phase so a restart gives a full first period
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
      tick      <= 1'b0;
    end else if (!run) begin
      count_reg <= '0;
      tick      <= 1'b0;
    end else if (step) begin
      if (count_reg >= modulus - W'(1)) begin
        count_reg <= '0;
        tick      <= 1'b1;
      end else begin
        count_reg <= count_reg + W'(1);
        tick      <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule : docc_tick_div

`default_nettype wire

// file: docc_clock_ctrl_asserts.sv
// Port checker for the dual oscillator clock controller
`default_nettype none

module docc_clock_ctrl_asserts #(
  parameter int STARTUP_SLOW = 4,
  parameter int STARTUP_FAST = 4
) (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       sleep_state,
  input wire logic       idle_state,
  input wire logic       brownout_reset,
  input wire logic       fast_clock,
  input wire logic       slow_clock,
  input wire logic       cpu_core_clock,
  input wire logic       instruction_clock,
  input wire logic       adc_sample_clock,
  input wire logic       fast_osc_running,
  input wire logic       slow_osc_running,
  input wire logic       cpu_released
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////
  // Register access
  sequence s_wr;
    reg_wr_en && reg_addr == docc_pkg::CSC_ADDR && !brownout_reset
      && !$past(brownout_reset, 2);
  endsequence
  sequence s_rd;
    reg_rd_en && !reg_wr_en && reg_addr == docc_pkg::CSC_ADDR
      && !brownout_reset;
  endsequence
  // Sleep only guards bits 1:0, so bits 4:2 always land
  property p_wr_rd;
    s_wr ##1 s_rd |=> reg_rd_data[4:2] == $past(reg_wr_data[4:2], 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("stored field not read back");
  property p_rd_zero;
    reg_rd_en && reg_addr != docc_pkg::CSC_ADDR |=> reg_rd_data == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("unmapped read not zero");
  property p_upper;
    reg_rd_data[7:5] == 3'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper bits not zero");

  ////////////////////////////////////////////////////////////
  // Oscillators and clocks
  property p_sleep_stop;
    sleep_state [*3] |-> !fast_osc_running && !slow_osc_running;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("oscillator running in sleep");
  property p_idle_instr;
    idle_state [*3] |-> !instruction_clock;
  endproperty
  a_idle_instr: assert property (p_idle_instr)
    else $error("instruction clock in idle");
  property p_instr_cpu;
    instruction_clock |-> $past(cpu_core_clock) || $past(cpu_core_clock, 2);
  endproperty
  a_instr_cpu: assert property (p_instr_cpu)
    else $error("instruction pulse without cpu pulse");
  property p_fast_one;
    fast_clock |=> !fast_clock;
  endproperty
  a_fast_one: assert property (p_fast_one)
    else $error("fast pulse longer than one cycle");
  property p_adc_gap;
    adc_sample_clock |=> !adc_sample_clock [*8];
  endproperty
  a_adc_gap: assert property (p_adc_gap)
    else $error("converter pulses too close");
  property p_cpu_gap;
    cpu_core_clock |=> !cpu_core_clock [*8];
  endproperty
  a_cpu_gap: assert property (p_cpu_gap)
    else $error("cpu pulses too close");
  property p_bor_drop;
    $rose(brownout_reset) |-> ##[2:5] !cpu_released;
  endproperty
  a_bor_drop: assert property (p_bor_drop)
    else $error("cpu not held on brown-out");
endmodule : docc_clock_ctrl_asserts

bind docc_clock_ctrl docc_clock_ctrl_asserts #(
  .STARTUP_SLOW(STARTUP_SLOW), .STARTUP_FAST(STARTUP_FAST)
) i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .sleep_state(sleep_state), .idle_state(idle_state),
  .brownout_reset(brownout_reset), .fast_clock(fast_clock),
  .slow_clock(slow_clock), .cpu_core_clock(cpu_core_clock),
  .instruction_clock(instruction_clock),
  .adc_sample_clock(adc_sample_clock),
  .fast_osc_running(fast_osc_running),
  .slow_osc_running(slow_osc_running), .cpu_released(cpu_released)
);

`default_nettype wire

// file: docc_clock_ctrl_tb.sv
// Self-checking bench for the dual oscillator clock controller
`default_nettype none

module docc_clock_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAIT_MIN = 4 * 3125;
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic       reg_rd_en = 1'b0;
  logic [7:0] reg_rd_data;
  logic       sleep_state = 1'b0;
  logic       idle_state = 1'b0;
  logic       brownout_reset = 1'b0;
  logic       fast_clock, slow_clock, cpu_core_clock, instruction_clock;
  logic       adc_sample_clock, fast_osc_running, slow_osc_running;
  logic       cpu_released;
  int         miscompares = 0;
  int         tests_run = 0;

  // Short start-up counts keep the run brief
  docc_clock_ctrl #(.STARTUP_SLOW(4), .STARTUP_FAST(4)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .sleep_state(sleep_state), .idle_state(idle_state),
    .brownout_reset(brownout_reset), .fast_clock(fast_clock),
    .slow_clock(slow_clock), .cpu_core_clock(cpu_core_clock),
    .instruction_clock(instruction_clock),
    .adc_sample_clock(adc_sample_clock),
    .fast_osc_running(fast_osc_running),
    .slow_osc_running(slow_osc_running), .cpu_released(cpu_released)
  );

  // System clock, 10 ns period
  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////
  // Helpers
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // Inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Leading cycle keeps a read and a write from sharing a time step
  task automatic wr(input logic [7:0] d);
    tick(1);
    reg_addr    = docc_pkg::CSC_ADDR;
    reg_wr_data = d;
    reg_wr_en   = 1'b1;
    tick(1);
    reg_wr_en   = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    tick(1);
    reg_rd_en = 1'b0;
    v         = reg_rd_data;
  endtask : rd

  function automatic logic sig(input int k);
    case (k)
      0:       return fast_clock;
      1:       return cpu_core_clock;
      2:       return adc_sample_clock;
      4:       return slow_clock;
      default: return instruction_clock;
    endcase
  endfunction : sig

  // Cycles from one pulse to the next, bounded
  task automatic gap(input int k, output int n);
    int i;
    n = 0;
    for (i = 0; i < 8000 && sig(k) !== 1'b1; i++) tick(1);
    do begin
      tick(1);
      n++;
    end while (sig(k) !== 1'b1 && n < 8000);
    if (n >= 8000) begin
      miscompares++;
      give_verdict();
    end
  endtask : gap

  task automatic wait_rel(output int n);
    n = 0;
    while (cpu_released !== 1'b1 && n < 20000) begin
      tick(1);
      n++;
    end
    if (n >= 20000) begin
      miscompares++;
      give_verdict();
    end
  endtask : wait_rel

  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reg();
    logic [7:0] v;
    rd(docc_pkg::CSC_ADDR, v);
    chk("reset_value", v, 8'h03);
    tick(1);
    rd(8'h37, v);
    chk("unmapped", v, 8'h00);
    wr(8'hFF);
    rd(docc_pkg::CSC_ADDR, v);
    chk("upper_bits", v, 8'h1F);
    wr(8'h0B);
  endtask : t_reg

  task automatic t_freq();
    int n;
    int c;
    int per[4] = '{50, 25, 12, 12};
    int ad[4] = '{2, 4, 8, 8};
    for (c = 0; c < 4; c++) begin
      wr({3'h0, 2'(c), 3'h3});
      repeat (2) gap(0, n);
      chk("fast_period", 16'(n), 16'(per[c]));
      repeat (2) gap(3, n);
      chk("instr_period", 16'(n), 16'(4 * per[c]));
      repeat (2) gap(2, n);
      chk("adc_period", 16'(n), 16'(ad[c] * per[c]));
    end
  endtask : t_freq

  // Switch takes effect only at an old-source pulse, hence three gaps
  task automatic t_src();
    int n;
    wr(8'h0F);
    repeat (3) gap(1, n);
    chk("cpu_slow_period", 16'(n), 16'(docc_pkg::SLOW_CYC));
    gap(4, n);
    chk("slow_period", 16'(n), 16'(docc_pkg::SLOW_CYC));
    wr(8'h0D);
    tick(4);
    chk("fast_off", 16'(fast_osc_running), 16'h0000);
    wr(8'h0A);
    tick(4);
    chk("slow_off", 16'(slow_osc_running), 16'h0000);
    chk("fast_on", 16'(fast_osc_running), 16'h0001);
    wr(8'h0B);
  endtask : t_src

  task automatic t_sleep();
    logic [7:0] v;
    sleep_state = 1'b1;
    tick(4);
    chk("sleep_fast", 16'(fast_osc_running), 16'h0000);
    chk("sleep_slow", 16'(slow_osc_running), 16'h0000);
    wr(8'h18);
    rd(docc_pkg::CSC_ADDR, v);
    chk("sleep_write", v, 8'h1B);
    sleep_state = 1'b0;
    tick(4);
    chk("wake_slow", 16'(slow_osc_running), 16'h0001);
    idle_state = 1'b1;
    tick(400);
    chk("idle_fast", 16'(fast_osc_running), 16'h0001);
    idle_state = 1'b0;
    wr(8'h0B);
  endtask : t_sleep

  task automatic t_bor();
    logic [7:0] v;
    int n;
    wr(8'h0F);
    brownout_reset = 1'b1;
    tick(6);
    chk("bor_hold", 16'(cpu_released), 16'h0000);
    wr(8'h1C);
    rd(docc_pkg::CSC_ADDR, v);
    chk("bor_value", v, 8'h03);
    brownout_reset = 1'b0;
    wait_rel(n);
    chk("bor_wait", 16'(n >= WAIT_MIN), 16'h0001);
  endtask : t_bor

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int n;
    tick(8);
    sys_rst = 1'b0;
    tick(3);
    chk("slow_start", 16'(slow_osc_running), 16'h0001);
    wait_rel(n);
    chk("start_wait", 16'(n >= WAIT_MIN), 16'h0001);
    t_reg();
    t_freq();
    t_src();
    t_sleep();
    t_bor();
    give_verdict();
  end
endmodule : docc_clock_ctrl_tb

`default_nettype wire
